// ===== hdl/ddcag_pkg.sv
// Purpose: shared constants for the gain stage and serial formatter
// Assumes: AXI4-Lite register access, 32-bit words
// Notes: offsets are byte addresses
package ddcag_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam logic [7:0] OFS_THR = 8'h08;
  localparam logic [7:0] OFS_GAINA = 8'h0C;
  localparam logic [7:0] OFS_GAINB = 8'h10;
  localparam logic [7:0] OFS_LIMIT = 8'h14;
  localparam logic [7:0] OFS_SER = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_ADJA = 8'h20;
  // control bit positions
  localparam int CTRL_FREEZE = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_RND_DIS = 2;
  localparam int CTRL_GAIN_MON = 3;
  localparam int CTRL_CDMA = 4;
  localparam int CTRL_EIGHT = 5;
  localparam int CTRL_ONESHOT = 6;
  localparam int CTRL_SSEL_FRZ = 8;
  localparam int CTRL_SSEL_GAIN = 11;
  localparam int CTRL_SSEL_SER = 14;
  localparam int CTRL_SSEL_INIT = 17;
  // reset values
  localparam logic [23:0] GAIN_RST = 24'h001000;
  localparam logic [15:0] AMAX_RST = 16'h7FFF;
  localparam logic [15:0] AMIN_RST = 16'h8000;
  localparam logic [31:0] SER_RST = 32'h0011_0010;
  // step field offset: code 0 means shift 3
  localparam logic [4:0] STEP_BASE = 5'h03;
  // widths
  localparam int GAIN_W = 24;
  localparam int DATA_W = 18;
  localparam int OUT_W = 25;
  typedef enum logic [1:0] {DDCAG_RESP_OKAY, DDCAG_RESP_EXOKAY, DDCAG_RESP_SLVERR,
    DDCAG_RESP_DECERR} ddcag_resp_e;
endpackage : ddcag_pkg

// ===== hdl/ddcag_ser.sv
// Purpose: serial bit shifter with frame strobe and bit clock divider
// Assumes: words loaded at frame start, one clock domain
// Notes: four lanes, MSB first
`timescale 1ns/10ps
module ddcag_ser
  import ddcag_pkg::*;
#(
  parameter int LANES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sync_evt,
  input wire logic [3:0] clkdiv,
  input wire logic [4:0] bits_m1,
  input wire logic [6:0] fsinvl,
  input wire logic [1:0] fsdel,
  input wire logic eight_pin_mode,
  input wire logic [OUT_W-1:0] word_i [LANES],
  output logic load,
  output logic ser_clk,
  output logic frame_strobe,
  output logic [LANES-1:0] ser_data
);
  logic [3:0] div_cnt;
  logic bit_en;
  logic [6:0] bit_cnt;
  logic [OUT_W-1:0] shreg [LANES];
  logic [6:0] fs_pos;
  logic [2:0] step;

  // bit clock enable: divide by clkdiv+1, restarted by sync
  always_ff @(posedge aclk) begin
    if (!aresetn || sync_evt || div_cnt == clkdiv) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end
  assign bit_en = (div_cnt == clkdiv); // [R22]

  // bit counter across the frame interval
  always_ff @(posedge aclk) begin
    if (!aresetn || sync_evt) begin
      bit_cnt <= 7'h00;
    end else if (bit_en) begin
      bit_cnt <= (bit_cnt >= fsinvl) ? 7'h00 : bit_cnt + 7'h01; // [R21]
    end
  end
  assign load = bit_en && bit_cnt == 7'h00;
  assign step = eight_pin_mode ? 3'h2 : 3'h1;

  // strobe position advanced ahead of the first data bit
  assign fs_pos = (fsdel == 2'h0) ? 7'h00 : fsinvl + 7'h01 - {5'h00, fsdel};

  // shift registers, one per lane, MSB first
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          shreg[g] <= '0;
        end else if (load) begin
          shreg[g] <= word_i[g] << (5'd24 - bits_m1); // [R18] [R19]
        end else if (bit_en) begin
          shreg[g] <= shreg[g] << step;
        end
      end
      // eight-pin mode: lanes 0-1 carry top I bits, lanes 2-3 top Q bits
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ser_data[g] <= 1'b0;
        end else if (eight_pin_mode) begin
          ser_data[g] <= shreg[(g < 2) ? 0 : 1][OUT_W-1-(g % 2)]; // [R20]
        end else begin
          ser_data[g] <= shreg[g][OUT_W-1];
        end
      end
    end
  endgenerate

  // frame strobe and bit clock out from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_strobe <= 1'b0;
      ser_clk <= 1'b0;
    end else begin
      frame_strobe <= (bit_cnt == fs_pos); // [R21]
      ser_clk <= (div_cnt <= {1'b0, clkdiv[3:1]});
    end
  end
endmodule : ddcag_ser

// ===== hdl/ddcag_top.sv
// Purpose: adaptive gain stage and serial output formatter for one DDC channel
// Assumes: AXI4-Lite master, syncs from pins on aclk domain
// Notes: parallel output, checksum and power meters are elsewhere
//
// What this block does
// R1 - process sample only when valid, I then Q
// R2 - UMTS one shared gain, CDMA two pairs
// R3 - two 24-bit gain words, A and B
// R4 - freeze holds accumulator, gain plus adjust
// R5 - clear zeroes adjustment accumulator
// R6 - freeze passes full 25-bit output
// R7 - freeze is register bit OR sync
// R8 - monitor word packs data, gain, state
// R9 - state bit0 saturated, bit1 zero
// R10 - step field value plus three
// R11 - mask low magnitude bits for zero test
// R12 - rounding field sets width, disable bit
// R13 - 8-bit threshold picks adjust direction
// R14 - zero count selects zero step size
// R15 - saturate count selects saturate step size
// R16 - adjustment held within 16-bit limits
// R17 - gain words double buffered on sync
// R18 - CDMA pins carry I,Q, 1-25 bits
// R19 - UMTS even/odd I,Q on four pins
// R20 - eight-pin mode sends top four bits
// R21 - strobe advanced 0-3, interval field 0-127
// R22 - bit clock divides by value plus one
// R23 - above threshold decrease, else increase
// R24 - 18x24 multiply, saturate before round
// R25 - up/down counters for zero and max
// R26 - stop adjusting beyond the limits
// R27 - single clock, cleared accumulator on reset
`timescale 1ns/10ps
module ddcag_top
  import ddcag_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] sync_pin,
  input wire logic sync_tc,
  input wire logic [DATA_W-1:0] sample_in,
  input wire logic sample_valid,
  output logic ser_clk,
  output logic frame_strobe,
  output logic [3:0] ser_data
);
  // ----------------------------------------------------------------
  // registers and bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl, step_r, thr_r, ser_r, limit_r;
  logic [23:0] gaina_sh, gainb_sh;
  logic aw_got, w_got;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic wr_fire;
  logic [3:0] sp_m, sp_s;
  logic oneshot;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign wr_fire = aw_got && w_got;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  logic addr_ok;
  assign addr_ok = aw_q <= OFS_SER && aw_q[1:0] == 2'b00;

  // register writes; one-shot bit self-clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= 32'h0000_C000 | (32'h6 << CTRL_SSEL_FRZ) | (32'h6 << CTRL_SSEL_INIT);
      step_r <= 32'h0;
      thr_r <= 32'h0;
      limit_r <= {AMAX_RST, AMIN_RST};
      ser_r <= SER_RST;
      gaina_sh <= GAIN_RST;
      gainb_sh <= GAIN_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DDCAG_RESP_OKAY;
    end else begin
      ctrl[CTRL_ONESHOT] <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok ? DDCAG_RESP_OKAY : DDCAG_RESP_SLVERR;
        unique case (aw_q)
          OFS_CTRL: ctrl <= merge(ctrl, w_q, ws_q);
          OFS_STEP: step_r <= merge(step_r, w_q, ws_q);
          OFS_THR: thr_r <= merge(thr_r, w_q, ws_q);
          OFS_GAINA: gaina_sh <= 24'(merge({8'h00, gaina_sh}, w_q, ws_q)); // [R3]
          OFS_GAINB: gainb_sh <= 24'(merge({8'h00, gainb_sh}, w_q, ws_q)); // [R3]
          OFS_LIMIT: limit_r <= merge(limit_r, w_q, ws_q);
          OFS_SER: ser_r <= merge(ser_r, w_q, ws_q);
          default: ;
        endcase
      end
    end
  end
  assign oneshot = ctrl[CTRL_ONESHOT];

  // ----------------------------------------------------------------
  // sync sources
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_m <= 4'h0;
      sp_s <= 4'h0;
    end else begin
      sp_m <= sync_pin; // [R27]
      sp_s <= sp_m;
    end
  end

  function automatic logic sel_sync(input logic [2:0] s, input logic [3:0] p,
                                    input logic tc, input logic os);
    logic r;
    r = 1'b0;
    unique case (s)
      3'h0, 3'h1, 3'h2, 3'h3: r = p[s[1:0]];
      3'h4: r = tc;
      3'h5: r = os;
      3'h6: r = 1'b0;
      3'h7: r = 1'b1;
    endcase
    return r;
  endfunction : sel_sync

  logic frz_sync, gain_sync, ser_sync, init_sync, freeze, clear;
  assign frz_sync = sel_sync(ctrl[CTRL_SSEL_FRZ +: 3], sp_s, sync_tc, oneshot);
  assign gain_sync = sel_sync(ctrl[CTRL_SSEL_GAIN +: 3], sp_s, sync_tc, oneshot);
  assign ser_sync = sel_sync(ctrl[CTRL_SSEL_SER +: 3], sp_s, sync_tc, oneshot);
  assign init_sync = sel_sync(ctrl[CTRL_SSEL_INIT +: 3], sp_s, sync_tc, oneshot);
  assign freeze = ctrl[CTRL_FREEZE] | frz_sync; // [R7]
  assign clear = ctrl[CTRL_CLEAR] | init_sync;

  // ----------------------------------------------------------------
  // gain datapath
  // ----------------------------------------------------------------
  logic [23:0] gaina, gainb;
  logic signed [24:0] adj [2];
  logic [1:0] phase; // bit0: Q sample, bit1: diversity pair
  logic cdma;
  logic path;
  logic [3:0] zcnt, scnt;
  logic [1:0] state_bits;
  assign cdma = ctrl[CTRL_CDMA];
  assign path = cdma & phase[1]; // [R2]

  // active gain words load on the gain sync event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gaina <= GAIN_RST;
      gainb <= GAIN_RST;
    end else if (gain_sync) begin
      gaina <= gaina_sh; // [R17]
      gainb <= gainb_sh;
    end
  end

  // sample sequencer: I, Q, I', Q' (even then odd pair in UMTS)
  always_ff @(posedge aclk) begin
    if (!aresetn || init_sync) begin
      phase <= 2'h0;
    end else if (sample_valid) begin
      phase <= phase + 2'h1; // [R1] [R19]
    end
  end

  logic signed [25:0] geff;
  logic signed [44:0] prod;
  logic signed [24:0] satv;
  logic [7:0] mag;
  logic is_zero, is_max;
  assign geff = $signed({2'b00, (path ? gainb : gaina)}) + 26'(adj[path]); // [R4]
  assign prod = 45'($signed(sample_in) * geff); // [R24]
  // saturate to 25 bits after dropping 12 fraction bits
  always_comb begin
    if (prod[44:36] != {9{prod[36]}}) begin
      satv = prod[44] ? 25'sh1000000 : 25'sh0FFFFFF; // [R24]
    end else begin
      satv = prod[36:12];
    end
  end
  assign mag = satv[24] ? 8'(~satv[24:17]) : satv[24:17]; // [R13]
  assign is_zero = (mag & ~{4'h0, step_r[19:16]}) == 8'h00; // [R11]
  assign is_max = mag == 8'h7F;

  // zero and saturation up/down counters
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      zcnt <= 4'h0;
      scnt <= 4'h0;
    end else if (sample_valid && !freeze) begin
      if (is_zero && zcnt != 4'hF) zcnt <= zcnt + 4'h1; // [R25]
      else if (!is_zero && zcnt != 4'h0) zcnt <= zcnt - 4'h1;
      if (is_max && scnt != 4'hF) scnt <= scnt + 4'h1; // [R25]
      else if (!is_max && scnt != 4'h0) scnt <= scnt - 4'h1;
    end
  end

  logic [3:0] dcode;
  logic [4:0] dshift;
  logic above;
  assign above = mag > thr_r[7:0]; // [R13]
  always_comb begin
    if (zcnt >= step_r[27:24] && step_r[27:24] != 4'h0) dcode = step_r[11:8]; // [R14]
    else if (scnt >= step_r[31:28] && step_r[31:28] != 4'h0) dcode = step_r[15:12]; // [R15]
    else if (above) dcode = step_r[7:4];
    else dcode = step_r[3:0];
  end
  assign dshift = {1'b0, dcode} + STEP_BASE; // [R10]

  logic signed [25:0] delta, nadj;
  logic signed [24:0] amax, amin;
  assign delta = geff >>> dshift;
  assign nadj = above ? 26'(adj[path]) - delta : 26'(adj[path]) + delta; // [R23]
  assign amax = 25'($signed({limit_r[31:16], 8'h00}));
  assign amin = 25'($signed({limit_r[15:0], 8'h00}));

  // adjustment accumulators, one per pair
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      adj[0] <= 25'sh0; // [R5] [R27]
      adj[1] <= 25'sh0;
    end else if (sample_valid && !freeze) begin // [R4]
      if (!above && nadj > 26'(amax)) adj[path] <= adj[path]; // [R16] [R26]
      else if (above && nadj < 26'(amin)) adj[path] <= adj[path]; // [R26]
      else adj[path] <= nadj[24:0];
    end
  end

  // ----------------------------------------------------------------
  // rounding and output words
  // ----------------------------------------------------------------
  logic [OUT_W-1:0] rnd, word_out;
  logic [4:0] drop;
  assign drop = 5'd7 + {1'b0, ser_r[19:16]}; // output_round_width
  always_comb begin
    if (freeze || ctrl[CTRL_RND_DIS]) begin
      rnd = satv; // [R6] [R12]
    end else begin
      rnd = ((satv + (25'h1 << (drop - 5'd1))) >> drop) << drop; // [R12]
    end
  end
  assign state_bits = {is_zero, is_max}; // [R9]
  always_comb begin
    if (!ctrl[CTRL_GAIN_MON]) word_out = rnd;
    else if (!phase[0]) word_out = {rnd[24:17], geff[23:16], 2'b00, 7'h00}; // [R8]
    else word_out = {rnd[24:17], geff[15:10], state_bits, 2'b00, 7'h00}; // [R8]
  end

  // capture words: lane order I, Q, I', Q' (even/odd in UMTS)
  logic [OUT_W-1:0] words [4];
  logic ld;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) words[i] <= '0;
    end else if (sample_valid) begin
      words[phase] <= word_out; // [R18] [R19]
    end
  end

  ddcag_ser #(.LANES(4)) u_ser (
    .aclk(aclk),
    .aresetn(aresetn),
    .sync_evt(ser_sync),
    .clkdiv(ser_r[3:0]),
    .bits_m1(ser_r[20:16] > 5'd24 ? 5'd24 : ser_r[20:16]),
    .fsinvl(ser_r[14:8]),
    .fsdel(ser_r[5:4]),
    .eight_pin_mode(ctrl[CTRL_EIGHT]),
    .word_i(words),
    .load(ld),
    .ser_clk(ser_clk),
    .frame_strobe(frame_strobe),
    .ser_data(ser_data)
  );

  // read path
  logic [31:0] rd_mux;
  always_comb begin
    unique case (s_axi_araddr)
      OFS_CTRL: rd_mux = ctrl;
      OFS_STEP: rd_mux = step_r;
      OFS_THR: rd_mux = thr_r;
      OFS_GAINA: rd_mux = {8'h00, gaina_sh};
      OFS_GAINB: rd_mux = {8'h00, gainb_sh};
      OFS_LIMIT: rd_mux = limit_r;
      OFS_SER: rd_mux = ser_r;
      OFS_STAT: rd_mux = {20'h0, ld, freeze, state_bits, zcnt, scnt};
      OFS_ADJA: rd_mux = {7'h00, adj[0]};
      default: rd_mux = 32'h0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= DDCAG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr <= OFS_ADJA && s_axi_araddr[1:0] == 2'b00) ?
                     DDCAG_RESP_OKAY : DDCAG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ddcag_top

// ===== dv/ddcag_asserts.sv
// Purpose: bus and output timing checks for the gain stage block
// Assumes: bound to ddcag_top, one clock domain
// Notes: read response checked against the captured read address
`timescale 1ns/10ps
module ddcag_asserts
  import ddcag_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ser_clk,
  input wire logic frame_strobe,
  input wire logic [3:0] ser_data
);
  logic [7:0] ar_q;
  // address of the read under way
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet:
    assert property (disable iff (1'h0) !aresetn |=> !ser_clk && !frame_strobe && ser_data == 4'h0)
    else $error("outputs not quiet after reset");
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_aw_refused:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ar_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_unmapped_err:
    assert property (s_axi_rvalid && ar_q > OFS_ADJA
      |-> s_axi_rresp == DDCAG_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay:
    assert property (s_axi_rvalid && ar_q <= OFS_ADJA && ar_q[1:0] == 2'h0
      |-> s_axi_rresp == DDCAG_RESP_OKAY)
    else $error("mapped read refused");
endmodule : ddcag_asserts
bind ddcag_top ddcag_asserts i_ddcag_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ser_clk(ser_clk),
  .frame_strobe(frame_strobe), .ser_data(ser_data));

// ===== dv/ddcag_rx_model.sv
// Purpose: downstream receiver that times the serial bit clock and frame strobe
// Assumes: passive, samples on aclk
// Notes: periods are counted in aclk cycles between rising edges
`timescale 1ns/10ps
module ddcag_rx_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ser_clk,
  input wire logic frame_strobe,
  input wire logic [3:0] ser_data,
  output int clk_per,
  output logic clk_evt,
  output int fs_per,
  output logic fs_evt,
  output logic [3:0] bit_val
);
  logic clk_q;
  logic fs_q;
  int clk_cnt;
  int fs_cnt;
  // bit clock period between rising edges
  always_ff @(posedge aclk) begin
    clk_q <= ser_clk;
    clk_evt <= 1'h0;
    clk_cnt <= clk_cnt + 1;
    if (!aresetn) begin
      clk_cnt <= 0;
    end else if (ser_clk && !clk_q) begin
      clk_per <= clk_cnt;
      bit_val <= ser_data;
      clk_cnt <= 1;
      clk_evt <= 1'h1;
    end
  end
  // frame strobe spacing
  always_ff @(posedge aclk) begin
    fs_q <= frame_strobe;
    fs_evt <= 1'h0;
    fs_cnt <= fs_cnt + 1;
    if (!aresetn) begin
      fs_cnt <= 0;
    end else if (frame_strobe && !fs_q) begin
      fs_per <= fs_cnt;
      fs_cnt <= 1;
      fs_evt <= 1'h1;
    end
  end
endmodule : ddcag_rx_model

// ===== dv/test_ddc_agc_serial_output.sv
// Purpose: self-checking bench for the gain stage and serial formatter
// Assumes: bready and rready held high, full byte strobes
// Notes: expectations queued by drivers, compared by the monitor
`timescale 1ns/10ps
module test_ddc_agc_serial_output
  import ddcag_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ddcag_exp_s;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb, sync_pin, ser_data, bit_val;
  logic rnd_on = 1'h1;
  logic [DATA_W-1:0] fix_val = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sync_tc, sample_valid, ser_clk, frame_strobe, clk_evt, fs_evt;
  logic [DATA_W-1:0] sample_in;
  int clk_per, fs_per;
  int error_cnt = 0;
  int samples_checked = 0;
  ddcag_exp_s e;
  ddcag_exp_s exp_rd[$];
  logic [1:0] exp_wr[$];
  int exp_per[$];
  int exp_fs[$];
  logic [3:0] exp_bits[$];
  ddcag_top i_ddcag_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sync_pin(sync_pin), .sync_tc(sync_tc), .sample_in(sample_in),
    .sample_valid(sample_valid), .ser_clk(ser_clk), .frame_strobe(frame_strobe),
    .ser_data(ser_data));
  ddcag_rx_model i_ddcag_rx_model (.aclk(aclk), .aresetn(aresetn), .ser_clk(ser_clk),
    .frame_strobe(frame_strobe), .clk_per(clk_per), .clk_evt(clk_evt), .fs_per(fs_per),
    .fs_evt(fs_evt), .ser_data(ser_data), .bit_val(bit_val));
  // clock, 40 ns period
  always #20 aclk = ~aclk;
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_d = 1'h0;
    logic w_d = 1'h0;
    exp_wr.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_d = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_d = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    exp_rd.push_back(ddcag_exp_s'{d, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
  endtask : rd
  // monitor: compares results with the oldest queued note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_rd.size() > 0) begin
      e = exp_rd.pop_front();
      check((s_axi_rdata & e.m) === (e.d & e.m), "read data");
      check(s_axi_rresp === e.r, "read response");
    end
    if (s_axi_bvalid && s_axi_bready && exp_wr.size() > 0) begin
      check(s_axi_bresp === exp_wr.pop_front(), "write response");
    end
    if (clk_evt && exp_per.size() > 0) begin
      check(clk_per === exp_per.pop_front(), "bit clock period");
    end
    if (fs_evt && exp_fs.size() > 0) begin
      check(fs_per === exp_fs.pop_front(), "frame interval");
    end
    if (clk_evt && exp_bits.size() > 0) begin
      check(bit_val === exp_bits.pop_front(), "serial lanes");
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sync_tc, sample_valid} = 5'h00;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, sync_pin} = 56'h0;
    s_axi_wstrb = 4'hF;
    sample_in = '0;
    void'($urandom(32'hB633));
    fork
      forever begin
        @(posedge aclk);
        sample_in <= rnd_on ? DATA_W'($urandom) : fix_val;
        sample_valid <= rnd_on ? 1'($urandom) : 1'h1;
      end
    join_none
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(OFS_SER, SER_RST, 32'hFFFF_FFFF, DDCAG_RESP_OKAY);
    rd(OFS_LIMIT, {AMAX_RST, AMIN_RST}, 32'hFFFF_FFFF, DDCAG_RESP_OKAY);
    rd(OFS_GAINA, {8'h00, GAIN_RST}, 32'h00FF_FFFF, DDCAG_RESP_OKAY);
    rd(OFS_GAINB, {8'h00, GAIN_RST}, 32'h00FF_FFFF, DDCAG_RESP_OKAY);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF, DDCAG_RESP_SLVERR);
    wr(8'h40, 32'h5A5A_5A5A, DDCAG_RESP_SLVERR);
    // every step code, back-to-back write and read
    for (int k = 0; k < 16; k++) begin
      v = $urandom;
      v[15:0] = {4{4'(k)}};
      wr(OFS_STEP, v, DDCAG_RESP_OKAY);
      rd(OFS_STEP, v, 32'hFF0F_FFFF, DDCAG_RESP_OKAY);
    end
    v = $urandom;
    wr(OFS_THR, v, DDCAG_RESP_OKAY);
    rd(OFS_THR, v, 32'h0000_00FF, DDCAG_RESP_OKAY);
    wr(OFS_CTRL, 32'h000C_C600, DDCAG_RESP_OKAY);
    repeat (200) @(posedge aclk);
    // freeze and clear set together leave only the programmed gain
    wr(OFS_CTRL, 32'h000C_C603, DDCAG_RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(OFS_ADJA, 32'h0, 32'hFFFF_FFFF, DDCAG_RESP_OKAY);
    // divider and strobe advance codes, serial sync on pin 3
    for (int i = 0; i < 4; i++) begin
      v = {11'h000, 5'h11, 1'h0, 7'h04, 2'h0, 2'(i), 4'((2 << i) - 1)};
      wr(OFS_SER, v, DDCAG_RESP_OKAY);
      sync_pin <= 4'h8;
      repeat (4) @(posedge aclk);
      sync_pin <= 4'h0;
      repeat (150) @(posedge aclk);
      exp_per.push_back(2 << i);
      exp_fs.push_back(5 * (2 << i)); // frame is fsinvl+1 bits
      while (exp_per.size() + exp_fs.size() > 0) @(posedge aclk);
    end
    // constant samples at unity gain, frozen, reach all four lanes
    rnd_on <= 1'h0;
    for (int j = 0; j < 2; j++) begin
      fix_val <= (j == 0) ? {DATA_W{1'h1}} : {DATA_W{1'h0}};
      repeat (200) @(posedge aclk);
      exp_bits.push_back((j == 0) ? 4'hF : 4'h0);
      while (exp_bits.size() > 0) @(posedge aclk);
    end
    repeat (10) @(posedge aclk);
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    #800000;
    error_cnt++;
    $display("CHECK FAILED %0t timeout", $time);
    print_verdict();
  end
endmodule : test_ddc_agc_serial_output
